// ### phy_strap_led_isolate_loopback_tb.sv
/*
  phy_strap_led_isolate_loopback_tb: drives the MAC side and line side
  of the PHY end and checks it. Assumes answers within eight cycles.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, (a), (b)); end end
module phy_strap_led_isolate_loopback_tb;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [4:0] strap = 5'h00;
  logic cfg = 1'h0, spd = 1'h0, fdx = 1'h0, pd = 1'h0;
  logic sd = 1'h0, lp = 1'h0, lc = 1'h0, vp = 1'h0, lrx = 1'h0;
  logic [15:0] rd;
  logic [3:0] v;
  int seed = 59710;
  int bad_count = 0;
  int n_checks = 0;
  wire logic [4:0] pin, oe;
  wire logic spd_led, ltx, lidle, glink;
  phyled_if mii ();
  // short loss timer keeps the run brief
  phyled_dev #(.LINK_LOSS_CYC(2000)) phyled_dev_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .mii(mii), .strap_address_input_in(strap),
    .indicator_cfg_strap_in(cfg), .an_speed100_in(spd),
    .an_full_duplex_in(fdx), .an_parallel_detect_in(pd),
    .line_signal_detect_in(sd), .line_link_pulse_in(lp),
    .line_valid_packet_in(vp), .line_rx_dv_in(lrx),
    .line_rxd_in(4'h0), .line_rx_er_in(1'h0), .line_collision_in(lc),
    .ind_pin_out(pin), .ind_oe_out(oe), .speed_indicator_out(spd_led),
    .line_tx_en_out(ltx), .line_txd_out(), .line_idle_en_out(lidle),
    .good_link_flag_out(glink));
  phyled_assertions phyled_assertions_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .strap_address_input_in(strap),
    .indicator_cfg_strap_in(cfg), .an_speed100_in(spd),
    .an_full_duplex_in(fdx), .an_parallel_detect_in(pd),
    .line_signal_detect_in(sd), .line_rx_dv_in(lrx), .ind_pin_out(pin),
    .ind_oe_out(oe), .speed_indicator_out(spd_led),
    .good_link_flag_out(glink), .tx_en(mii.tx_en), .crs(mii.crs),
    .col(mii.col), .mii_oe(mii.mii_oe));
  // 100 MHz clock
  always #5 clk_in = ~clk_in;
  // active level of a shared indicator is its strap inverted
  function automatic logic lvl(input logic act, input logic s);
    return act ^ s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // one management request, held until answered
  task automatic mg(input logic w, input logic [4:0] a,
      input logic [4:0] r, input logic [15:0] d);
    int k;
    mii.mg_write = w;
    mii.mg_phy_addr = a;
    mii.mg_reg = r;
    mii.mg_wdata = d;
    mii.mg_valid = 1'h1;
    k = 0;
    // a write is taken at the first edge; a read answers at that same edge
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (!w && mii.mg_rvalid !== 1'h1 && k < 8);
    rd = mii.mg_rdata;
    if (!w) `CHK(mii.mg_rvalid, 1'h1)
    mii.mg_valid = 1'h0;
    tick(1);
  endtask
  task automatic restart(input logic [4:0] s);
    strap = s;
    cfg = 1'($random(seed));
    rst_n_in = 1'h0;
    tick(20);
    rst_n_in = 1'h1;
    tick(20);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the sequence needs about 16000 cycles
  initial begin
    #400000;
    bad_count++;
    print_verdict;
  end
  initial begin
    {mii.txd, mii.tx_en, mii.tx_er, mii.mg_valid} = 7'h00;
    {mii.mg_write, mii.mg_phy_addr, mii.mg_reg, mii.mg_wdata} = 27'h0;
    for (int i = 0; i < 3; i++) begin
      restart(i == 0 ? 5'h1F : 5'($random(seed)) | 5'h01);
      mg(1'h0, strap, phyled_pkg::REG_PHY_CTRL, 16'h0000);
      `CHK(rd[4:0], strap)
      mg(1'h0, strap, phyled_pkg::REG_BASIC_CTRL, 16'h0000);
      `CHK(rd, phyled_pkg::BASIC_CTRL_RST)
      `CHK(mii.mii_oe, 1'h1)
      repeat (30) begin
        {spd, fdx, pd, lc, lrx} = 5'($random(seed));
        tick(12);
        `CHK(spd_led, spd)
        `CHK(mii.crs, lrx)
        if (fdx & ~pd) `CHK(mii.col, 1'h0)
        `CHK(pin[0], lvl(fdx & ~pd, cfg & strap[0]))
        if (fdx & ~pd) `CHK(pin[1], strap[1])
        else if (!spd) `CHK(pin[1], lvl(mii.col, strap[1]))
      end
      {spd, fdx, pd, sd} = 4'h9;
      lrx = 1'h0;
      tick(20);
      `CHK(glink, 1'h1)
      `CHK(pin[2], lvl(1'h1, strap[2]))
      {spd, sd} = 2'h0;
      tick(2100);
      `CHK(glink, 1'h0)
      // one packet gives link, the loss timer takes it away
      vp = 1'h1;
      tick(1);
      vp = 1'h0;
      tick(20);
      `CHK(glink, 1'h1)
      tick(2100);
      `CHK(glink, 1'h0)
      for (int p = 1; p <= 7; p++) begin
        lp = 1'h1;
        tick(1);
        lp = 1'h0;
        tick(20);
        `CHK(glink, p == 7)
      end
      // isolate: transmit ignored, management still answered
      mg(1'h1, strap, phyled_pkg::REG_BASIC_CTRL, 16'h3400);
      mii.tx_en = 1'h1;
      tick(50);
      `CHK(mii.mii_oe, 1'h0)
      `CHK(ltx, 1'h0)
      `CHK(lidle, 1'h1)
      mii.tx_en = 1'h0;
      mg(1'h0, strap, phyled_pkg::REG_BASIC_CTRL, 16'h0000);
      `CHK(rd, 16'h3400)
      spd = 1'h1;
      mg(1'h1, strap, phyled_pkg::REG_BASIC_CTRL, 16'h6000);
      mg(1'h0, strap, phyled_pkg::REG_PHY_STATUS, 16'h0000);
      `CHK(rd[phyled_pkg::PS_LOOPBACK], 1'h1)
      v = 4'($random(seed));
      mii.txd = v;
      mii.tx_en = 1'h1;
      tick(120);
      `CHK(mii.rx_dv, 1'h1)
      `CHK(mii.rxd, v)
      `CHK(mii.crs, 1'h1)
      `CHK(ltx, 1'h0)
      mii.tx_en = 1'h0;
      // 10M loopback: link forced, line driver off first
      spd = 1'h0;
      mg(1'h1, strap, phyled_pkg::REG_TEN_STATUS_CTRL, 16'h0001);
      mg(1'h1, strap, phyled_pkg::REG_LINE_DRV_CTRL, 16'h0000);
      mg(1'h1, strap, phyled_pkg::REG_BASIC_CTRL, 16'h4000);
      v = 4'($random(seed));
      mii.txd = v;
      mii.tx_en = 1'h1;
      tick(250);
      `CHK(mii.rxd, v)
      `CHK(ltx, 1'h0)
      `CHK(glink, 1'h1)
      mii.tx_en = 1'h0;
      // address zero written, not strapped: no isolation
      mg(1'h1, strap, phyled_pkg::REG_PHY_CTRL, 16'h0000);
      mg(1'h0, 5'h00, phyled_pkg::REG_PHY_CTRL, 16'h0000);
      `CHK(mii.mii_oe, 1'h1)
    end
    restart(5'h00);
    `CHK(mii.mii_oe, 1'h0)
    mg(1'h0, 5'h00, phyled_pkg::REG_PHY_CTRL, 16'h0000);
    `CHK(rd[4:0], 5'h00)
    print_verdict;
  end
endmodule // phy_strap_led_isolate_loopback_tb

// ### phyled_assertions.sv
/*
  phyled_assertions: checks on the MII and indicator signals.
  Assumes straps stay steady from reset onwards.
*/
`timescale 1ns/1ns
module phyled_assertions (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] strap_address_input_in,
  input wire logic indicator_cfg_strap_in,
  input wire logic an_speed100_in,
  input wire logic an_full_duplex_in,
  input wire logic an_parallel_detect_in,
  input wire logic line_signal_detect_in,
  input wire logic line_rx_dv_in,
  input wire logic [4:0] ind_pin_out,
  input wire logic [4:0] ind_oe_out,
  input wire logic speed_indicator_out,
  input wire logic good_link_flag_out,
  input wire logic tx_en,
  input wire logic crs,
  input wire logic col,
  input wire logic mii_oe
);
  // resolved duplex; parallel detect never yields full
  wire logic fdx = an_full_duplex_in & ~an_parallel_detect_in;
  wire logic [4:0] s = strap_address_input_in;
  wire logic cfg = indicator_cfg_strap_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_speed_follows:
    assert property ($stable(an_speed100_in)[*8] |->
      speed_indicator_out == an_speed100_in) else $error("speed led");
  a_col_led_fdx:
    assert property ((fdx && $stable(fdx))[*8] |->
      !ind_oe_out[1] || ind_pin_out[1] == s[1]) else $error("col led");
  a_dup_led_level:
    assert property (($stable(fdx) && $stable(cfg))[*8] |->
      !ind_oe_out[0] || ind_pin_out[0] == (fdx ^ (cfg & s[0])))
      else $error("duplex led");
  a_link_led_level:
    assert property ($stable(good_link_flag_out)[*8] |-> !ind_oe_out[2]
      || ind_pin_out[2] == (good_link_flag_out ^ s[2]))
      else $error("link led");
  a_sigdet_link:
    assert property ($rose(line_signal_detect_in) && an_speed100_in
      |-> ##[1:16] good_link_flag_out) else $error("no link");
  a_fdx_no_col:
    assert property (fdx[*8] |-> !mii_oe || !col) else $error("col");
  a_fdx_crs_rx:
    assert property ((fdx && !line_rx_dv_in)[*8] |-> !mii_oe || !crs)
      else $error("crs in full duplex");
  a_hdx_crs_tx:
    assert property ($rose(tx_en) && !fdx && mii_oe |-> ##[1:100] crs)
      else $error("no crs");
endmodule // phyled_assertions

// ### phyled_dev.sv
/*
  phyled_dev: PHY end: strap capture, indicators, link detect, duplex
  dependent carrier and collision, isolate, loopback and the control
  and status registers on the management path.
  Assumes the line-side inputs come from receive logic on clk_in and
  the resolved negotiation result arrives on an_* inputs.
*/
`timescale 1ns/1ns
module phyled_dev #(
  parameter int unsigned LINK_LOSS_CYC = phyled_pkg::LINK_LOSS_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  phyled_if.dev mii,
  input wire logic [4:0] strap_address_input_in,
  input wire logic indicator_cfg_strap_in,
  input wire logic an_speed100_in,
  input wire logic an_full_duplex_in,
  input wire logic an_parallel_detect_in,
  input wire logic line_signal_detect_in,
  input wire logic line_link_pulse_in,
  input wire logic line_valid_packet_in,
  input wire logic line_rx_dv_in,
  input wire logic [3:0] line_rxd_in,
  input wire logic line_rx_er_in,
  input wire logic line_collision_in,
  output logic [4:0] ind_pin_out,
  output logic [4:0] ind_oe_out,
  output logic speed_indicator_out,
  output logic line_tx_en_out,
  output logic [3:0] line_txd_out,
  output logic line_idle_en_out,
  output logic good_link_flag_out
);
  phyled_pkg::phyled_strap_state_type state_q;
  logic [1:0] settle_q;
  logic [4:0] strap_v, stable_v, active_v, adjust_v;
  logic cfg1_q, cfg2_q, cfg3_q, cfg_q, strap_zero_q;
  logic [15:0] basic_control_reg_q, ten_meg_status_ctrl_reg_q;
  logic [15:0] line_driver_ctrl_reg_q;
  logic [4:0] phy_control_reg_q;
  logic [2:0] pulse_cnt_q;
  logic [phyled_pkg::LOSS_W-1:0] loss_cnt_q;
  logic good10_q, link_q;
  logic [5:0] nib_cnt_q;
  logic nib_stb_q;
  logic [5:0] lb_pipe_q [phyled_pkg::LOOP_PIPE];
  logic [3:0] rxd_q;
  logic rx_dv_q, rx_er_q, crs_q, col_q, mii_oe_q;
  logic [15:0] rdata_q;
  logic rvalid_q, spd_q, ltx_en_q, lidle_q, load_q;
  logic [3:0] ltxd_q;

  // resolved operating mode, forced or negotiated
  wire an_en = basic_control_reg_q[phyled_pkg::BC_AN_EN];
  wire speed100 = an_en ? an_speed100_in
                        : basic_control_reg_q[phyled_pkg::BC_SPEED];
  wire full = an_en ? (an_full_duplex_in & ~an_parallel_detect_in)
                    : basic_control_reg_q[phyled_pkg::BC_DUPLEX];
  wire loop = basic_control_reg_q[phyled_pkg::BC_LOOPBACK];
  wire isolate = basic_control_reg_q[phyled_pkg::BC_ISOLATE]
                 | strap_zero_q;
  wire drv_en = line_driver_ctrl_reg_q[phyled_pkg::LD_ENABLE];
  wire force10 = ten_meg_status_ctrl_reg_q[phyled_pkg::TS_FORCE_LINK];
  wire tx_act = mii.tx_en & ~isolate;
  wire run = (state_q == phyled_pkg::ST_RUN);
  wire capture = (state_q == phyled_pkg::ST_CAPTURE) & (&stable_v)
                 & (cfg2_q == cfg3_q);

  // strap pins, one slot per shared indicator
  assign active_v[phyled_pkg::IND_DUPLEX] = full;
  assign active_v[phyled_pkg::IND_COL] = col_q;
  assign active_v[phyled_pkg::IND_LINK] = link_q;
  assign active_v[phyled_pkg::IND_TX] = tx_act;
  assign active_v[phyled_pkg::IND_RX] = rx_dv_q;
  assign adjust_v = {4'hF, cfg_q};
  genvar gi;
  generate
    for (gi = 0; gi < phyled_pkg::ADDR_W; gi++) begin : g_ind
      phyled_ind u_ind (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(strap_address_input_in[gi]),
        .capture_in(capture),
        .run_in(run),
        .active_in(active_v[gi]),
        .adjust_in(adjust_v[gi]),
        .pin_out(ind_pin_out[gi]),
        .pin_oe_out(ind_oe_out[gi]),
        .strap_out(strap_v[gi]),
        .stable_out(stable_v[gi])
      );
    end
  endgenerate

  // capture sequence: let the synchronisers fill, then latch once
  always_ff @(posedge clk_in) begin
    cfg1_q <= indicator_cfg_strap_in;
    cfg2_q <= cfg1_q;
    cfg3_q <= cfg2_q;
    if (!rst_n_in) begin
      state_q <= phyled_pkg::ST_SETTLE;
      settle_q <= 2'h0;
      cfg_q <= 1'b0;
      strap_zero_q <= 1'b0;
    end else begin
      unique case (state_q)
        phyled_pkg::ST_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == phyled_pkg::STRAP_SETTLE) begin
            state_q <= phyled_pkg::ST_CAPTURE;
          end
        end
        phyled_pkg::ST_CAPTURE: begin
          if (capture) begin
            cfg_q <= cfg3_q;
            state_q <= phyled_pkg::ST_RUN;
          end
        end
        // straps are latched by now and held until the next reset
        phyled_pkg::ST_RUN: begin
          strap_zero_q <= (strap_v == 5'h00);
        end
        default: state_q <= phyled_pkg::ST_SETTLE;
      endcase
    end
  end

  // management decode; answered whether isolated or not
  wire hit = mii.mg_valid & (mii.mg_phy_addr == phy_control_reg_q);
  wire wr = hit & mii.mg_write;
  wire wr_bc = wr & (mii.mg_reg == phyled_pkg::REG_BASIC_CTRL);
  wire wr_pc = wr & (mii.mg_reg == phyled_pkg::REG_PHY_CTRL);
  wire wr_ts = wr & (mii.mg_reg == phyled_pkg::REG_TEN_STATUS_CTRL);
  wire wr_ld = wr & (mii.mg_reg == phyled_pkg::REG_LINE_DRV_CTRL);
  wire [15:0] status_v = {12'h000, loop, full, ~speed100, link_q};
  wire [15:0] rd_mux =
    (mii.mg_reg == phyled_pkg::REG_BASIC_CTRL) ? basic_control_reg_q :
    (mii.mg_reg == phyled_pkg::REG_PHY_STATUS) ? status_v :
    (mii.mg_reg == phyled_pkg::REG_PHY_CTRL) ? {11'h000, phy_control_reg_q} :
    (mii.mg_reg == phyled_pkg::REG_TEN_STATUS_CTRL) ?
      ten_meg_status_ctrl_reg_q :
    (mii.mg_reg == phyled_pkg::REG_LINE_DRV_CTRL) ? line_driver_ctrl_reg_q :
    16'h0000;

  // control registers; a write of address zero does not isolate
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      basic_control_reg_q <= phyled_pkg::BASIC_CTRL_RST;
      ten_meg_status_ctrl_reg_q <= phyled_pkg::TEN_STATUS_RST;
      line_driver_ctrl_reg_q <= phyled_pkg::LINE_DRV_RST;
      phy_control_reg_q <= 5'h00;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      if (wr_bc) basic_control_reg_q <= mii.mg_wdata;
      if (wr_ts) ten_meg_status_ctrl_reg_q <= mii.mg_wdata;
      if (wr_ld) line_driver_ctrl_reg_q <= mii.mg_wdata;
      // address loads a cycle after capture, once strap_v holds it
      load_q <= capture;
      if (load_q) phy_control_reg_q <= strap_v;
      else if (wr_pc) phy_control_reg_q <= mii.mg_wdata[4:0];
      rvalid_q <= hit & ~mii.mg_write;
      rdata_q <= rd_mux;
    end
  end

  // 10M link: pulses or a packet set it, silence ends it
  localparam int unsigned LOSS_LAST_I = LINK_LOSS_CYC - 1;
  localparam logic [phyled_pkg::LOSS_W-1:0] LOSS_LAST =
    LOSS_LAST_I[phyled_pkg::LOSS_W-1:0];
  localparam logic [phyled_pkg::LOSS_W-1:0] LOSS_ONE =
    {{(phyled_pkg::LOSS_W-1){1'b0}}, 1'b1};
  wire pulse_seen = line_link_pulse_in | line_valid_packet_in;
  wire loss_done = (loss_cnt_q == LOSS_LAST);
  wire pulses_full =
    (pulse_cnt_q == phyled_pkg::LINK_PULSES_GOOD - 3'h1);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pulse_cnt_q <= 3'h0;
      loss_cnt_q <= '0;
      good10_q <= 1'b0;
    end else if (pulse_seen) begin
      loss_cnt_q <= '0;
      if (pulse_cnt_q != phyled_pkg::LINK_PULSES_GOOD) begin
        pulse_cnt_q <= pulse_cnt_q + 3'h1;
      end
      if (line_valid_packet_in || pulses_full) begin
        good10_q <= 1'b1;
      end
    end else if (loss_done) begin
      // a lost link must count seven fresh pulses again, or see one packet
      loss_cnt_q <= '0;
      pulse_cnt_q <= 3'h0;
      good10_q <= 1'b0;
    end else begin
      loss_cnt_q <= loss_cnt_q + LOSS_ONE;
    end
  end

  // nibble timing, loopback source and line transmit gating
  wire [5:0] nib_last = speed100 ? phyled_pkg::NIB_CYC_100 - 6'h1
                                 : phyled_pkg::NIB_CYC_10 - 6'h1;
  wire [5:0] lb_in = {tx_act, mii.tx_er & ~isolate, mii.txd};
  wire [5:0] rx_src = loop ? lb_pipe_q[phyled_pkg::LOOP_PIPE-1]
                           : {line_rx_dv_in, line_rx_er_in, line_rxd_in};
  // 10M loopback relies on software turning the driver off
  wire line_tx = tx_act & (speed100 ? ~loop : drv_en);

  // loopback delay line, one stage per nibble
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < phyled_pkg::LOOP_PIPE; i++) begin
        lb_pipe_q[i] <= 6'h00;
      end
    end else if (nib_stb_q) begin
      lb_pipe_q[0] <= lb_in;
      for (int i = 1; i < phyled_pkg::LOOP_PIPE; i++) begin
        lb_pipe_q[i] <= lb_pipe_q[i-1];
      end
    end
  end

  // registered MII, line and indicator sources
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_q <= 1'b0;
      nib_cnt_q <= 6'h00;
      nib_stb_q <= 1'b0;
      spd_q <= 1'b0;
      ltx_en_q <= 1'b0;
      ltxd_q <= 4'h0;
      lidle_q <= 1'b1;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
      rxd_q <= 4'h0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      mii_oe_q <= 1'b0;
    end else begin
      link_q <= speed100 ? line_signal_detect_in
                         : (good10_q | force10);
      nib_stb_q <= (nib_cnt_q == nib_last);
      nib_cnt_q <= (nib_cnt_q >= nib_last) ? 6'h00 : nib_cnt_q + 6'h01;
      spd_q <= speed100;
      ltx_en_q <= line_tx;
      ltxd_q <= line_tx ? mii.txd : 4'h0;
      lidle_q <= ~line_tx;
      rx_dv_q <= rx_src[5];
      rx_er_q <= rx_src[4];
      rxd_q <= rx_src[3:0];
      crs_q <= rx_src[5] | (~full & tx_act);
      col_q <= ~full & ~loop & line_collision_in;
      mii_oe_q <= ~isolate;
    end
  end

  // every output comes straight from a flop
  assign mii.nib_stb = nib_stb_q;
  assign mii.rxd = rxd_q;
  assign mii.rx_dv = rx_dv_q;
  assign mii.rx_er = rx_er_q;
  assign mii.crs = crs_q;
  assign mii.col = col_q;
  assign mii.mii_oe = mii_oe_q;
  assign mii.mg_rdata = rdata_q;
  assign mii.mg_rvalid = rvalid_q;
  assign speed_indicator_out = spd_q;
  assign line_tx_en_out = ltx_en_q;
  assign line_txd_out = ltxd_q;
  assign line_idle_en_out = lidle_q;
  assign good_link_flag_out = link_q;
endmodule // phyled_dev

// ### phyled_if.sv
/*
  phyled_if: MII data signals and a parallel management path between
  the PHY end and the MAC end.
  Assumes both ends share clk; released outputs carry an enable.
*/
`timescale 1ns/1ns
interface phyled_if;
  logic [3:0] txd;
  logic tx_en;
  logic tx_er;
  logic nib_stb;
  logic [3:0] rxd;
  logic rx_dv;
  logic rx_er;
  logic crs;
  logic col;
  logic mii_oe;
  logic mg_valid;
  logic mg_write;
  logic [4:0] mg_phy_addr;
  logic [4:0] mg_reg;
  logic [15:0] mg_wdata;
  logic [15:0] mg_rdata;
  logic mg_rvalid;
  modport dev (
    input txd, tx_en, tx_er, mg_valid, mg_write, mg_phy_addr, mg_reg,
    mg_wdata,
    output nib_stb, rxd, rx_dv, rx_er, crs, col, mii_oe, mg_rdata,
    mg_rvalid
  );
  modport mac (
    output txd, tx_en, tx_er, mg_valid, mg_write, mg_phy_addr, mg_reg,
    mg_wdata,
    input nib_stb, rxd, rx_dv, rx_er, crs, col, mii_oe, mg_rdata,
    mg_rvalid
  );
endinterface // phyled_if

// ### phyled_ind.sv
/*
  phyled_ind: one dual purpose strap / indicator pin.
  Assumes the pin level is asynchronous; capture_in is a one cycle
  pulse given only while stable_out is high.
*/
`timescale 1ns/1ns
module phyled_ind (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic capture_in,
  input wire logic run_in,
  input wire logic active_in,
  input wire logic adjust_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic strap_out,
  output logic stable_out
);
  logic s1_q, s2_q, s3_q;
  logic strap_q, pin_q, oe_q;
  logic drive_d;

  // three stage synchroniser; only stages two and three are compared
  always_ff @(posedge clk_in) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  assign stable_out = (s2_q == s3_q);
  // drive against the strap so the led sinks or sources current
  assign drive_d = adjust_in ? (active_in ^ strap_q) : active_in;

  // pin is released until the strap has been read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strap_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (capture_in) begin
        strap_q <= s3_q;
      end
      pin_q <= drive_d;
      oe_q <= run_in;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_out = oe_q;
  assign strap_out = strap_q;
endmodule // phyled_ind

// ### phyled_pkg.sv
/*
  phyled_pkg: constants and types shared by both ends of the PHY strap,
  indicator, isolate and loopback logic.
  Assumes one 100 MHz clock on both ends; no registers live here.
*/
package phyled_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NUM_ADDR = 32;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // nibble periods at 25 MHz and 2.5 MHz
  localparam int unsigned NIB_PERIOD_100_NS = 40;
  localparam int unsigned NIB_PERIOD_10_NS = 400;
  localparam logic [5:0] NIB_CYC_100 =
    6'(NIB_PERIOD_100_NS / CLK_PERIOD_NS);
  localparam logic [5:0] NIB_CYC_10 =
    6'(NIB_PERIOD_10_NS / CLK_PERIOD_NS);
  localparam int unsigned LINK_LOSS_MS = 50;
  localparam int unsigned LINK_LOSS_CYC =
    LINK_LOSS_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LOSS_W = 23;
  localparam logic [2:0] LINK_PULSES_GOOD = 3'h7;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam int unsigned LOOP_PIPE = 3;
  localparam logic [2:0] MG_TIMEOUT = 3'h4;
  // register indices on the management path
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_PHY_STATUS = 5'h10;
  localparam logic [4:0] REG_PHY_CTRL = 5'h19;
  localparam logic [4:0] REG_TEN_STATUS_CTRL = 5'h1A;
  localparam logic [4:0] REG_LINE_DRV_CTRL = 5'h1B;
  localparam int unsigned BC_LOOPBACK = 14;
  localparam int unsigned BC_SPEED = 13;
  localparam int unsigned BC_AN_EN = 12;
  localparam int unsigned BC_ISOLATE = 10;
  localparam int unsigned BC_DUPLEX = 8;
  localparam int unsigned PS_LINK = 0;
  localparam int unsigned PS_SPEED10 = 1;
  localparam int unsigned PS_DUPLEX = 2;
  localparam int unsigned PS_LOOPBACK = 3;
  localparam int unsigned TS_FORCE_LINK = 0;
  localparam int unsigned LD_ENABLE = 15;
  localparam logic [15:0] BASIC_CTRL_RST = 16'h3000;
  localparam logic [15:0] TEN_STATUS_RST = 16'h0000;
  localparam logic [15:0] LINE_DRV_RST = 16'h8000;
  localparam logic [15:0] NO_ANSWER = 16'hFFFF;
  // indicator pin slots, in strap bit order
  localparam int unsigned IND_DUPLEX = 0;
  localparam int unsigned IND_COL = 1;
  localparam int unsigned IND_LINK = 2;
  localparam int unsigned IND_TX = 3;
  localparam int unsigned IND_RX = 4;
  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_CAPTURE = 2'h1,
    ST_RUN = 2'h3
  } phyled_strap_state_type;
endpackage
